/* logic/cgrf_clk_filter.sv */
// Spike filter for the main oscillator with a recovery indicator.
`timescale 1ns/1ps
`default_nettype none
module cgrf_clk_filter
#(
   parameter int MIN_PHASE = cgrf_pkg::MIN_PHASE_CYC,
   parameter int GOOD_COUNT = cgrf_pkg::GOOD_EDGES
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Control
   input wire logic run,
   // Oscillator
   input wire logic osc_in,
   // Filtered result
   output logic filt_out,
   output logic edge_seen,
   output logic good
);
   localparam int PW = $clog2(MIN_PHASE + 1);
   localparam int GW = $clog2(GOOD_COUNT + 1);
   localparam logic [PW-1:0] PHASE_LAST = PW'(MIN_PHASE - 1);
   localparam logic [GW-1:0] GOOD_MAX = GW'(GOOD_COUNT);

   logic osc_reg;
   logic [PW-1:0] phase_reg;
   logic [GW-1:0] good_reg;

   if (MIN_PHASE < 2 || GOOD_COUNT < 1)
   begin : g_param_check
      $error("cgrf_clk_filter: MIN_PHASE must be at least 2 and GOOD_COUNT at least 1.");
   end

   // ------------------------------------------------------------
   // Phase qualification
   // ------------------------------------------------------------
   // A level change passes only after it has stood MIN_PHASE cycles; shorter pulses are spikes.
   always_ff @(posedge sys_clk)
   begin
      if (srst || !run)
      begin
         osc_reg <= 1'b0;
         phase_reg <= '0;
         filt_out <= 1'b0;
         edge_seen <= 1'b0;
         good_reg <= '0;
      end
      else
      begin
         osc_reg <= osc_in;
         edge_seen <= 1'b0;
         if (osc_reg != filt_out)
         begin
            if (phase_reg == PHASE_LAST)
            begin
               filt_out <= osc_reg;
               edge_seen <= 1'b1;
               phase_reg <= '0;
               if (good_reg != GOOD_MAX)
               begin
                  good_reg <= good_reg + 1'b1;
               end
            end
            else
            begin
               phase_reg <= phase_reg + 1'b1;
            end
         end
         else
         begin
            if (phase_reg != '0)
            begin
               good_reg <= '0;
            end
            phase_reg <= '0;
         end
      end
   end

   assign good = (good_reg == GOOD_MAX);
endmodule
`default_nettype wire

/* logic/cgrf_clock_guard.sv */
// Clock guard with backup clock switch-over, status register and reset flags.
//
// Contract
// - Guard enable comes from a static option, captured at reset, not a register.
// - Spikes on the main clock are filtered out before reaching the core.
// - A misbehaving oscillator may be fully suppressed; recovery resumes it automatically.
// - No main edge within one backup period selects the backup clock.
// - Return to the main clock happens automatically once it recovers.
// - Backup selection due to failure sets the clock-failure flag, bit 1.
// - Status read clears the failure flag only after main clock recovery.
// - With the guard disabled, failure flag reads zero and enable is inert.
// - Interrupt needs flag set, enable bit 2 set and CPU mask clear.
// - Interrupt enable is written by software only; 1 enables, 0 disables.
// - Guard runs in wait; its interrupt wakes wait but never halt.
// - In halt the status register freezes and the guard stays off.
// - Halt exit by interrupt keeps configuration; by reset restarts from reset values.
// - Bits 7:5 and 3 read zero and ignore writes.
// - Undervolt flag set by undervolt reset, cleared only by writing zero.
// - Dog flag set by watchdog reset, cleared by writing zero or undervolt reset.
// - Undervolt flag survives later pin and watchdog resets.
// - Flags encode last reset: pin 00, watchdog 01, undervolt 1x.
// - Reset loads all zero except the two reset-source flags.
// - Interrupt uses the fixed vector pair and priority slot 2.
`timescale 1ns/1ps
`default_nettype none
module cgrf_clock_guard
#(
   parameter int WATCH_CYC = cgrf_pkg::BACKUP_WATCH_CYC,
   parameter int MIN_PHASE = cgrf_pkg::MIN_PHASE_CYC,
   parameter int GOOD_COUNT = cgrf_pkg::GOOD_EDGES
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Static options and reset causes
   input wire logic guard_option,
   input wire logic rst_cause_undervolt,
   input wire logic rst_cause_dog,
   // CPU state
   input wire logic cpu_irq_mask,
   input wire logic cpu_wait,
   input wire logic cpu_halt,
   // Oscillators and core clock
   input wire logic main_osc,
   input wire logic backup_osc,
   output logic core_clk,
   output logic backup_active,
   // Interrupt
   output logic fail_irq,
   output logic wake_from_wait,
   output logic [15:0] irq_vector,
   output logic [3:0] irq_priority,
   // Avalon-MM slave
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int WW = $clog2(WATCH_CYC + 1);
   localparam logic [WW-1:0] WATCH_LAST = WW'(WATCH_CYC - 1);

   logic guard_en_reg;
   logic run;
   logic filt_run;
   logic main_filt;
   logic main_edge;
   logic main_good;
   logic backup_reg;
   logic [WW-1:0] since_edge_reg;
   logic timeout;
   cgrf_pkg::cgrf_sel_e sel_reg;
   logic fail_evt;
   logic fail_flag_reg;
   logic fail_irq_en_reg;
   logic undervolt_reset_flag_reg;
   logic dog_reset_flag_reg;
   logic [7:0] status_view;
   logic ack_reg;
   logic hit;
   logic bus_done;
   logic wr_done;
   logic rd_done;

   if (WATCH_CYC < 2 * MIN_PHASE + 2)
   begin : g_param_check
      $error("cgrf_clock_guard: WATCH_CYC too short for the filter phase length.");
   end

   // ------------------------------------------------------------
   // Option capture and run gating
   // ------------------------------------------------------------
   // The option is a static strap, so it is sampled only while reset is held.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         guard_en_reg <= guard_option;
      end
   end

   assign run = guard_en_reg && !cpu_halt;

   // The filter restarts on a switch to backup, so a return needs fresh good edges.
   assign filt_run = !cpu_halt && (sel_reg != cgrf_pkg::SEL_TO_BACKUP);

   // ------------------------------------------------------------
   // Main clock filter and watch
   // ------------------------------------------------------------
   cgrf_clk_filter
   #(
      .MIN_PHASE(MIN_PHASE),
      .GOOD_COUNT(GOOD_COUNT)
   )
   u_filter
   (
      .sys_clk(sys_clk),
      .srst(srst),
      .run(filt_run),
      .osc_in(main_osc),
      .filt_out(main_filt),
      .edge_seen(main_edge),
      .good(main_good)
   );

   always_ff @(posedge sys_clk)
   begin
      if (srst || !run || main_edge)
      begin
         since_edge_reg <= '0;
      end
      else if (since_edge_reg != WATCH_LAST)
      begin
         since_edge_reg <= since_edge_reg + 1'b1;
      end
   end

   assign timeout = run && (since_edge_reg == WATCH_LAST) && !main_edge;

   always_ff @(posedge sys_clk)
   begin
      if (srst || !run)
      begin
         backup_reg <= 1'b0;
      end
      else
      begin
         backup_reg <= backup_osc;
      end
   end

   // ------------------------------------------------------------
   // Clock selection
   // ------------------------------------------------------------
   // Changeover parks the core clock low and hands over only on a low source level.
   always_ff @(posedge sys_clk)
   begin
      if (srst || !run)
      begin
         sel_reg <= cgrf_pkg::SEL_MAIN;
      end
      else
      begin
         unique case (sel_reg)
            cgrf_pkg::SEL_MAIN:
            begin
               if (timeout)
               begin
                  sel_reg <= cgrf_pkg::SEL_TO_BACKUP;
               end
            end
            cgrf_pkg::SEL_TO_BACKUP:
            begin
               if (!backup_reg)
               begin
                  sel_reg <= cgrf_pkg::SEL_BACKUP;
               end
            end
            cgrf_pkg::SEL_BACKUP:
            begin
               if (main_good && !backup_reg)
               begin
                  sel_reg <= cgrf_pkg::SEL_TO_MAIN;
               end
            end
            cgrf_pkg::SEL_TO_MAIN:
            begin
               if (!main_filt)
               begin
                  sel_reg <= cgrf_pkg::SEL_MAIN;
               end
            end
         endcase
      end
   end

   assign fail_evt = (sel_reg == cgrf_pkg::SEL_MAIN) && timeout;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         core_clk <= 1'b0;
      end
      else if (!guard_en_reg || sel_reg == cgrf_pkg::SEL_MAIN)
      begin
         core_clk <= main_filt;
      end
      else if (sel_reg == cgrf_pkg::SEL_BACKUP)
      begin
         core_clk <= backup_reg;
      end
      else
      begin
         core_clk <= 1'b0;
      end
   end

   assign backup_active = (sel_reg != cgrf_pkg::SEL_MAIN);

   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   // Every access waits one cycle; read data is registered at the end of the wait cycle, effects land on the completing edge.
   assign hit = (avs_address == cgrf_pkg::CRS_BYTE_ADDR);
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   assign bus_done = ack_reg && (avs_read || avs_write);
   assign wr_done = bus_done && avs_write && hit && avs_byteenable[0] && !cpu_halt;
   assign rd_done = bus_done && avs_read && hit && !cpu_halt;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         ack_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         avs_readdata <= 32'h0000_0000;
      end
      else if ((avs_read && !ack_reg) && hit)
      begin
         avs_readdata <= {24'h00_0000, status_view};
      end
      else if (avs_read && !ack_reg)
      begin
         avs_readdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Status register
   // ------------------------------------------------------------
   always_comb
   begin
      status_view = cgrf_pkg::CRS_RESET_VALUE;
      status_view[cgrf_pkg::FAIL_FLAG_BIT] = fail_flag_reg && guard_en_reg;
      status_view[cgrf_pkg::FAIL_IRQ_EN_BIT] = fail_irq_en_reg;
      status_view[cgrf_pkg::UNDERVOLT_FLAG_BIT] = undervolt_reset_flag_reg;
      status_view[cgrf_pkg::DOG_FLAG_BIT] = dog_reset_flag_reg;
   end

   // Hardware set beats the read clear in the same cycle.
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         fail_flag_reg <= 1'b0;
      end
      else if (fail_evt)
      begin
         fail_flag_reg <= 1'b1;
      end
      else if (rd_done && sel_reg == cgrf_pkg::SEL_MAIN)
      begin
         fail_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         fail_irq_en_reg <= 1'b0;
      end
      else if (wr_done)
      begin
         fail_irq_en_reg <= avs_writedata[cgrf_pkg::FAIL_IRQ_EN_BIT];
      end
   end

   // Reset-source flags are kept through srst; only the cause inputs and writes move them.
   always_ff @(posedge sys_clk)
   begin
      if (rst_cause_undervolt)
      begin
         undervolt_reset_flag_reg <= 1'b1;
      end
      else if (wr_done && !avs_writedata[cgrf_pkg::UNDERVOLT_FLAG_BIT])
      begin
         undervolt_reset_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst_cause_undervolt)
      begin
         dog_reset_flag_reg <= 1'b0;
      end
      else if (rst_cause_dog)
      begin
         dog_reset_flag_reg <= 1'b1;
      end
      else if (wr_done && !avs_writedata[cgrf_pkg::DOG_FLAG_BIT])
      begin
         dog_reset_flag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   assign fail_irq = fail_flag_reg && fail_irq_en_reg && !cpu_irq_mask && guard_en_reg;
   assign wake_from_wait = fail_irq && cpu_wait && !cpu_halt;
   assign irq_vector = cgrf_pkg::IRQ_VECTOR_ADDR;
   assign irq_priority = cgrf_pkg::IRQ_PRIORITY_SLOT;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_fail;
      fail_evt;
   endsequence

   sequence s_status_read;
      rd_done;
   endsequence

   property p_fail_sets_flag;
      @(posedge sys_clk) disable iff (srst)
      s_fail |=> fail_flag_reg && sel_reg == cgrf_pkg::SEL_TO_BACKUP;
   endproperty
   a_fail_sets_flag: assert property (p_fail_sets_flag)
      else $error("Failure event did not set the flag.");

   property p_timeout_moves;
      @(posedge sys_clk) disable iff (srst)
      (sel_reg == cgrf_pkg::SEL_MAIN && timeout) |=> sel_reg == cgrf_pkg::SEL_TO_BACKUP;
   endproperty
   a_timeout_moves: assert property (p_timeout_moves)
      else $error("Main clock timeout did not start backup changeover.");

   property p_read_keeps;
      @(posedge sys_clk) disable iff (srst)
      (s_status_read and (sel_reg != cgrf_pkg::SEL_MAIN) and fail_flag_reg) |=> fail_flag_reg;
   endproperty
   a_read_keeps: assert property (p_read_keeps)
      else $error("Flag cleared while backup clock still selected.");

   property p_read_clears;
      @(posedge sys_clk) disable iff (srst)
      (s_status_read and (sel_reg == cgrf_pkg::SEL_MAIN) and !fail_evt) |=> !fail_flag_reg;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("Flag not cleared by read after recovery.");

   property p_irq_cause;
      @(posedge sys_clk) disable iff (srst)
      fail_irq |-> status_view[1] && status_view[2] && !cpu_irq_mask;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("Interrupt raised without all its conditions.");

   property p_reserved_zero;
      @(posedge sys_clk) disable iff (srst)
      bus_done |-> avs_readdata[7:5] == 3'h0 && avs_readdata[3] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Reserved status bits read non-zero.");

   property p_halt_freeze;
      @(posedge sys_clk) disable iff (srst)
      (cpu_halt && $past(cpu_halt)) |-> $stable(status_view);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze)
      else $error("Status changed during halt.");

   property p_disabled_zero;
      @(posedge sys_clk) disable iff (srst)
      !guard_en_reg |-> !status_view[1] && !fail_irq && !backup_active;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero)
      else $error("Disabled guard shows failure activity.");

   property p_returns;
      @(posedge sys_clk) disable iff (srst)
      (run && sel_reg == cgrf_pkg::SEL_BACKUP && main_good && !backup_reg)
         |=> sel_reg == cgrf_pkg::SEL_TO_MAIN;
   endproperty
   a_returns: assert property (p_returns)
      else $error("Recovered main clock not reselected.");

   property p_high_phase;
      @(posedge sys_clk) disable iff (srst)
      $rose(core_clk) |-> core_clk [*2];
   endproperty
   a_high_phase: assert property (p_high_phase)
      else $error("Core clock high phase shortened.");

   property p_undervolt_flags;
      @(posedge sys_clk)
      rst_cause_undervolt |=> undervolt_reset_flag_reg && !dog_reset_flag_reg;
   endproperty
   a_undervolt_flags: assert property (p_undervolt_flags)
      else $error("Undervolt reset flags wrong.");
endmodule
`default_nettype wire

/* logic/cgrf_pkg.sv */
// Package of constants for the clock guard and reset flag block.
package cgrf_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CRS_INDEX = 8'h25;
   localparam logic [9:0] CRS_BYTE_ADDR = {CRS_INDEX, 2'b00};
   localparam logic [7:0] CRS_RESET_VALUE = 8'h00;
   localparam int DOG_FLAG_BIT = 0;
   localparam int FAIL_FLAG_BIT = 1;
   localparam int FAIL_IRQ_EN_BIT = 2;
   localparam int UNDERVOLT_FLAG_BIT = 4;

   // ------------------------------------------------------------
   // Interrupt identity
   // ------------------------------------------------------------
   localparam logic [15:0] IRQ_VECTOR_ADDR = 16'hFFF6;
   localparam logic [3:0] IRQ_PRIORITY_SLOT = 4'h2;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 50;
   localparam int BACKUP_PERIOD_NS = 4000;
   localparam int BACKUP_WATCH_CYC = BACKUP_PERIOD_NS / SYS_CLK_PERIOD_NS;
   localparam int MIN_PHASE_NS = 100;
   localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int GOOD_EDGES = 8;

   // ------------------------------------------------------------
   // Clock selection states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SEL_MAIN, SEL_TO_BACKUP, SEL_BACKUP, SEL_TO_MAIN} cgrf_sel_e;
endpackage

/* sim/cgrf_clock_guard_test.sv */
// Self-checking testbench of the clock guard and reset flag block.
`timescale 1ns/1ps
`default_nettype none
module cgrf_clock_guard_test;
   logic sys_clk, srst, guard_option, rst_cause_undervolt, rst_cause_dog;
   logic cpu_irq_mask, cpu_wait, cpu_halt, avs_read, avs_write;
   logic [1:0] mode;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic main_osc, backup_osc, core_clk, backup_active, fail_irq, wake_from_wait;
   logic avs_waitrequest;
   logic [15:0] irq_vector;
   logic [3:0] irq_priority;
   logic [31:0] avs_readdata;
   int miscompares = 0;
   int checks = 0;
   int n;
   logic [1:0] m;

   // ------------------------------------------------------------
   // Design, oscillators and clock
   // ------------------------------------------------------------
   cgrf_clock_guard #(.WATCH_CYC(20), .MIN_PHASE(2), .GOOD_COUNT(2)) cgrf_clock_guard_i (
      .sys_clk(sys_clk), .srst(srst), .guard_option(guard_option),
      .rst_cause_undervolt(rst_cause_undervolt), .rst_cause_dog(rst_cause_dog),
      .cpu_irq_mask(cpu_irq_mask), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
      .main_osc(main_osc), .backup_osc(backup_osc), .core_clk(core_clk),
      .backup_active(backup_active), .fail_irq(fail_irq), .wake_from_wait(wake_from_wait),
      .irq_vector(irq_vector), .irq_priority(irq_priority), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   cgrf_osc_model cgrf_osc_model_i (.sys_clk(sys_clk), .mode(mode), .main_osc(main_osc),
      .backup_osc(backup_osc));

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int k;
      k = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_read <= ~w;
      avs_write <= w;
      do
      begin
         @(posedge sys_clk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 20)
      begin
         chk(32'h0000DEAD, 32'h00000000);
      end
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask

   task automatic wr(input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, cgrf_pkg::CRS_BYTE_ADDR, d, q);
   endtask

   task automatic do_reset(input logic opt, input logic uv, input logic dog);
      @(posedge sys_clk);
      srst <= 1'b1;
      guard_option <= opt;
      rst_cause_undervolt <= uv;
      rst_cause_dog <= dog;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      rst_cause_undervolt <= 1'b0;
      rst_cause_dog <= 1'b0;
   endtask

   // Waits a bounded span for the backup selection to reach the wanted level.
   task automatic wait_backup(input logic want);
      int k;
      k = 0;
      while (backup_active !== want && k < 300)
      begin
         @(negedge sys_clk);
         k++;
      end
      chk({31'h0, backup_active}, {31'h0, want});
   endtask

   task automatic settle();
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Watchdog and test sequence
   // ------------------------------------------------------------
   initial
   begin
      #(50 * 20000);
      miscompares++;
      wrap_up();
   end

   initial
   begin
      srst = 1'b1;
      guard_option = 1'b1;
      rst_cause_undervolt = 1'b1;
      rst_cause_dog = 1'b0;
      cpu_irq_mask = 1'b0;
      cpu_wait = 1'b0;
      cpu_halt = 1'b0;
      mode = 2'd0;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h1;
      do_reset(1'b1, 1'b1, 1'b0);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h10);
      wr(8'hFF);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h14);
      wr(8'h04);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h04);
      wr(8'h00);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h00);
      rd(10'h000, 32'h00);
      chk({16'h0, irq_vector}, 32'h0000FFF6);
      chk({28'h0, irq_priority}, 32'h2);
      $display("test register access done");

      do_reset(1'b1, 1'b1, 1'b1);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h10);
      do_reset(1'b1, 1'b0, 1'b1);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h11);
      do_reset(1'b1, 1'b0, 1'b0);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h11);
      wr(8'h00);
      do_reset(1'b1, 1'b0, 1'b1);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h01);
      wr(8'h00);
      do_reset(1'b1, 1'b0, 1'b0);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h00);
      $display("test reset flags done");

      repeat (8) @(negedge sys_clk);
      m[0] = core_clk;
      n = 0;
      repeat (40)
      begin
         @(negedge sys_clk);
         if (core_clk !== m[0]) n++;
         m[0] = core_clk;
      end
      chk(n, 32'd10);
      for (int i = 0; i < 2; i++)
      begin
         m = (i == 0) ? 2'd1 : 2'd2;
         wr(8'h04);
         mode <= m;
         wait_backup(1'b1);
         rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h06);
         rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h06);
         settle();
         chk({31'h0, fail_irq}, 32'h1);
         @(posedge sys_clk);
         cpu_irq_mask <= 1'b1;
         settle();
         chk({31'h0, fail_irq}, 32'h0);
         @(posedge sys_clk);
         cpu_irq_mask <= 1'b0;
         cpu_wait <= 1'b1;
         settle();
         chk({31'h0, wake_from_wait}, 32'h1);
         @(posedge sys_clk);
         cpu_wait <= 1'b0;
         mode <= 2'd0;
         wait_backup(1'b0);
         rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h06);
         rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h04);
         settle();
         chk({31'h0, fail_irq}, 32'h0);
      end
      $display("test clock failure done");

      @(posedge sys_clk);
      cpu_halt <= 1'b1;
      mode <= 2'd1;
      repeat (100) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h0, backup_active}, 32'h0);
      wr(8'h00);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h04);
      cpu_halt <= 1'b0;
      mode <= 2'd0;
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h04);
      $display("test halt done");

      do_reset(1'b0, 1'b0, 1'b0);
      wr(8'h04);
      mode <= 2'd1;
      repeat (100) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h0, backup_active}, 32'h0);
      chk({31'h0, fail_irq}, 32'h0);
      rd(cgrf_pkg::CRS_BYTE_ADDR, 32'h04);
      mode <= 2'd0;
      $display("test guard disabled done");
      wrap_up();
   end
endmodule
`default_nettype wire

/* sim/cgrf_osc_model.sv */
// Behavioural model of the main and backup oscillators that feed the clock guard.
`timescale 1ns/1ps
`default_nettype none
module cgrf_osc_model
#(
   parameter int MAIN_HALF = 4,
   parameter int BACKUP_HALF = 10
)
(
   // Clock
   input wire logic sys_clk,
   // Behaviour select: 0 running, 1 stopped, 2 spiking at every cycle
   input wire logic [1:0] mode,
   // Oscillator levels
   output logic main_osc,
   output logic backup_osc
);
   int main_cnt = 0;
   int backup_cnt = 0;

   initial main_osc = 1'b0;
   initial backup_osc = 1'b0;

   // A spiking oscillator flips every cycle, which the guard must treat as no clock.
   always @(posedge sys_clk)
   begin
      if (mode == 2'd2)
      begin
         main_osc <= ~main_osc;
         main_cnt <= 0;
      end
      else if (mode == 2'd0)
      begin
         main_cnt <= (main_cnt == MAIN_HALF - 1) ? 0 : main_cnt + 1;
         if (main_cnt == MAIN_HALF - 1)
         begin
            main_osc <= ~main_osc;
         end
      end
   end

   always @(posedge sys_clk)
   begin
      backup_cnt <= (backup_cnt == BACKUP_HALF - 1) ? 0 : backup_cnt + 1;
      if (backup_cnt == BACKUP_HALF - 1)
      begin
         backup_osc <= ~backup_osc;
      end
   end
endmodule
`default_nettype wire
